/* verilog/bsm_pkg.sv */
// Behaviour
// - chip select with read strobe drives register; with store strobe it stores
// - reset clears all registers, then reset control bit 0 reads set
// - reset control write clears pointers; bit 0 resets all registers
// - device strobe causes one device transfer per clock it stands, seen on the third clock edge (fourth in maximum mode)
// - maximum mode multiplexes low and high address bytes on low lines
// - maximum mode strobes high byte into host or device latch
// - host latch enable in maximum, address bit 12 in extended mode
// - device latch enable in maximum, address bit 13 in extended mode
// - memory select on every buffer access, store enable on writes
// - busy drive from control bit 7 or arbitration phase
// - target pick output follows control bit 6
// - pick sense input restarts arbitration bus free search
// - two settable outputs mark slave and master roles
// - bus enables from transfer logic or control bits 2 and 3
// - request asks host for transfer; acknowledge answers it
// - halt pointer equal to active pointer sets done bit, halts handshake
// - new halt pointer write resumes handshake if still enabled
// - low host port gives host bus; write pulses data hold strobe
// - high host port is same for upper host byte
// - buffer window read selects memory; write also enables store
// - transfer control write starts transfers and sets direction
// - buffer size and extended bit choose addressing mode
// - maximum mode when size exceeds 1K, or 16K when extended
// - device transfers served before host transfers
package bsm_pkg;
	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] host_bus_low_port = 8'h50;
	localparam logic [7:0] host_bus_high_port = 8'h51;
	localparam logic [7:0] host_interface_control = 8'h52;
	localparam logic [7:0] transfer_control = 8'h53;
	localparam logic [7:0] buffer_size = 8'h54;
	localparam logic [7:0] address_mode_control = 8'h55;
	localparam logic [7:0] reset_control = 8'h59;
	localparam logic [7:0] read_pointer_low = 8'h5a;
	localparam logic [7:0] read_pointer_high = 8'h5b;
	localparam logic [7:0] write_pointer_low = 8'h5c;
	localparam logic [7:0] write_pointer_high = 8'h5d;
	localparam logic [7:0] halt_pointer_low = 8'h5e;
	localparam logic [7:0] halt_pointer_high = 8'h5f;
	localparam logic [7:0] buffer_window_port = 8'h70;
	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int hic_busy_bit = 7;
	localparam int hic_pick_bit = 6;
	localparam int hic_arb_bit = 5;
	localparam int hic_master_bit = 4;
	localparam int hic_out_en_bit = 3;
	localparam int hic_in_en_bit = 2;
	localparam int hic_slave_bit = 1;
	localparam int tc_done_bit = 5;
	localparam int tc_dir_bit = 4;
	localparam int tc_host_run_bit = 0;
	localparam int amc_ext_bit = 0;
	localparam int rst_ctl_bit = 0;
	// buffer size register holds size in 256-byte pages minus one
	localparam logic [7:0] size_min_limit = 8'h03;
	localparam logic [7:0] size_ext_limit = 8'h3f;
	// bus free cycles and settle cycles before arbitration phase
	localparam logic [2:0] bus_free_cycles = 3'h3;
	localparam logic [2:0] arb_delay_cycles = 3'h4;
	localparam logic [7:0] reset_value = 8'h00;
	typedef enum {addr_min, addr_ext, addr_max} addr_mode_t;
endpackage

/* verilog/bsm_arbiter.sv */
// bus free search then arbitration phase
module bsm_arbiter
	import bsm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic arb_enable,
	input wire logic busy_sense,
	input wire logic pick_sense,
	// status
	output logic arb_phase
);
	typedef enum {st_search, st_settle, st_arbitrate} arb_state_t;
	arb_state_t state_r;
	logic [2:0] count_r;

	// -----------------------------------------------------------
	// sequencer
	// -----------------------------------------------------------
	// pick sense wins over everything so a selection restarts search
	always_ff @(posedge clk)
	begin
		if (rst || pick_sense)
		begin
			state_r <= st_search;
			count_r <= 3'h0;
		end
		else
		begin
			unique case (state_r)
				st_search:
				begin
					if (busy_sense)
						count_r <= 3'h0;
					else if (count_r == bus_free_cycles - 3'h1)
					begin
						count_r <= 3'h0;
						if (arb_enable)
							state_r <= st_settle;
					end
					else
						count_r <= count_r + 3'h1;
				end
				st_settle:
				begin
					if (count_r == arb_delay_cycles - 3'h1)
						state_r <= st_arbitrate;
					count_r <= count_r + 3'h1;
				end
				st_arbitrate:
				begin
					if (!arb_enable)
						state_r <= st_search;
					count_r <= 3'h0;
				end
			endcase
		end
	end

	assign arb_phase = (state_r == st_arbitrate);
endmodule

/* verilog/bsm_addr_mux.sv */
// maps a 16-bit buffer address onto the pin set of each mode
module bsm_addr_mux
	import bsm_pkg::*;
(
	// mode and phase
	input addr_mode_t mode,
	input wire logic high_phase,
	input wire logic host_access,
	input wire logic device_access,
	// address
	input wire logic [15:0] addr,
	// pins, latch enables active low
	output logic [7:0] addr_low,
	output logic pin_a8,
	output logic pin_a9,
	output logic [1:0] pin_a10_11,
	output logic pin_a12,
	output logic pin_a13
);
	always_comb
	begin
		addr_low = addr[7:0];
		pin_a8 = addr[8];
		pin_a9 = addr[9];
		pin_a10_11 = addr[11:10];
		pin_a12 = 1'b1;
		pin_a13 = 1'b1;
		unique case (mode)
			addr_min:
				pin_a10_11 = 2'b00;
			addr_ext:
			begin
				pin_a12 = addr[12];
				pin_a13 = addr[13];
			end
			addr_max:
			begin
				// high byte first, caught by the latch strobe
				addr_low = high_phase ? addr[15:8] : addr[7:0];
				pin_a8 = high_phase && host_access;
				pin_a9 = high_phase && device_access;
				pin_a12 = !(host_access && !high_phase);
				pin_a13 = !(device_access && !high_phase);
			end
		endcase
	end
endmodule

/* verilog/buffer_storage_manager_io.sv */
// buffer storage manager: register file, port arbiter and handshake
module buffer_storage_manager_io
	import bsm_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// reset pin, active low, asynchronous to clk
	input wire logic reset_pin_n,
	// microprocessor bus
	input wire logic chip_select,
	input wire logic addr_latch_en,
	input wire logic read_strobe,
	input wire logic store_strobe,
	input wire logic [7:0] mux_bus_in,
	output logic [7:0] mux_bus_out,
	output logic mux_bus_oe_n,
	// device port
	input wire logic device_transfer_strobe,
	// buffer memory
	output logic [7:0] buf_addr_low,
	output logic host_latch_strobe,
	output logic device_latch_strobe,
	output logic [1:0] buf_addr_mid,
	output logic host_latch_output_en,
	output logic device_latch_output_en,
	output logic memory_select,
	output logic buffer_store_en,
	// bus arbitration pins
	input wire logic busy_sense_in,
	input wire logic pick_sense_in,
	output logic busy_drive_out,
	output logic target_pick_out,
	output logic slave_role_out,
	output logic master_role_out,
	// host port
	output logic bus_input_enable,
	output logic bus_output_enable,
	output logic data_hold_strobe,
	input wire logic host_ack,
	output logic host_req
);
	import bsm_pkg::*;

	// -----------------------------------------------------------
	// input synchronisers
	// -----------------------------------------------------------
	// every pin crosses two flops; only stage two is ever read
	localparam int n_sync = 9;
	logic [n_sync-1:0] sync1_r;
	logic [n_sync-1:0] sync2_r;
	logic [n_sync-1:0] pins;
	assign pins = {reset_pin_n, chip_select, addr_latch_en, read_strobe, store_strobe,
		device_transfer_strobe, busy_sense_in, pick_sense_in, host_ack};
	always_ff @(posedge clk)
	begin
		sync1_r <= pins;
		sync2_r <= sync1_r;
	end
	logic rst_pin_n, cs_s, ale_s, rd_s, wr_s, dev_s, busy_s, pick_s, ack_s;
	assign {rst_pin_n, cs_s, ale_s, rd_s, wr_s, dev_s, busy_s, pick_s, ack_s} = sync2_r;

	// data and address are stable while strobes are, so they are sampled
	// once more alongside the strobe to align them
	logic [7:0] bus_d1_r, bus_d2_r, reg_addr_r;
	logic wr_d_r, ale_d_r, rd_d_r;
	always_ff @(posedge clk)
	begin
		bus_d1_r <= mux_bus_in;
		bus_d2_r <= bus_d1_r;
		wr_d_r <= rst ? 1'b0 : wr_s;
		rd_d_r <= rst ? 1'b0 : rd_s;
		ale_d_r <= rst ? 1'b0 : ale_s;
	end
	always_ff @(posedge clk)
	begin
		if (rst)
			reg_addr_r <= reset_value;
		else if (ale_d_r && !ale_s)
			reg_addr_r <= bus_d2_r; // address taken at latch enable fall
	end

	// one store per strobe, taken at its leading edge
	logic store_ev;
	assign store_ev = cs_s && wr_s && !wr_d_r;
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// -----------------------------------------------------------
	// register file
	// -----------------------------------------------------------
	logic [7:0] hic_r, tc_r, size_r, amc_r;
	logic [15:0] rd_ptr_r, wr_ptr_r, halt_ptr_r;
	logic rst_flag_r, soft_rst;
	logic wipe;
	logic dev_go, host_go, done_set;
	assign soft_rst = store_ev && hit(reg_addr_r, reset_control)
		&& bus_d2_r[rst_ctl_bit];
	assign wipe = rst || !rst_pin_n || soft_rst;

	// control registers
	always_ff @(posedge clk)
	begin
		if (wipe)
		begin
			hic_r <= reset_value;
			size_r <= reset_value;
			amc_r <= reset_value;
		end
		else if (store_ev)
		begin
			if (hit(reg_addr_r, host_interface_control))
				hic_r <= bus_d2_r;
			if (hit(reg_addr_r, buffer_size))
				size_r <= bus_d2_r;
			if (hit(reg_addr_r, address_mode_control))
				amc_r <= bus_d2_r;
		end
	end

	// transfer control: a write starts work and sets direction; done is sticky
	always_ff @(posedge clk)
	begin
		if (wipe)
			tc_r <= reset_value;
		else
		begin
			if (store_ev && hit(reg_addr_r, transfer_control))
				tc_r <= bus_d2_r;
			if (done_set)
				tc_r[tc_done_bit] <= 1'b1;
		end
	end

	// reset flag stands after any reset until software writes reset control with bit 0 clear
	always_ff @(posedge clk)
	begin
		if (wipe)
			rst_flag_r <= 1'b1;
		else if (store_ev && hit(reg_addr_r, reset_control))
			rst_flag_r <= 1'b0;
	end

	// pointers: cleared by any reset control write, incremented per byte
	logic ptr_clr;
	assign ptr_clr = wipe || (store_ev && hit(reg_addr_r, reset_control));
	logic dir_in;
	assign dir_in = tc_r[tc_dir_bit]; // disk to memory when set
	always_ff @(posedge clk)
	begin
		if (ptr_clr)
		begin
			rd_ptr_r <= 16'h0000;
			wr_ptr_r <= 16'h0000;
			halt_ptr_r <= 16'h0000;
		end
		else
		begin
			if (store_ev && hit(reg_addr_r, read_pointer_low))
				rd_ptr_r[7:0] <= bus_d2_r;
			if (store_ev && hit(reg_addr_r, read_pointer_high))
				rd_ptr_r[15:8] <= bus_d2_r;
			if (store_ev && hit(reg_addr_r, write_pointer_low))
				wr_ptr_r[7:0] <= bus_d2_r;
			if (store_ev && hit(reg_addr_r, write_pointer_high))
				wr_ptr_r[15:8] <= bus_d2_r;
			if (store_ev && hit(reg_addr_r, halt_pointer_low))
				halt_ptr_r[7:0] <= bus_d2_r;
			if (store_ev && hit(reg_addr_r, halt_pointer_high))
				halt_ptr_r[15:8] <= bus_d2_r;
			// disk reads fill at the write pointer, host drains at read pointer
			if ((dev_go && dir_in) || (host_go && !dir_in))
				wr_ptr_r <= wr_ptr_r + 16'h0001;
			if ((dev_go && !dir_in) || (host_go && dir_in))
				rd_ptr_r <= rd_ptr_r + 16'h0001;
		end
	end

	// -----------------------------------------------------------
	// addressing mode
	// -----------------------------------------------------------
	addr_mode_t mode;
	always_comb
	begin
		if (amc_r[amc_ext_bit])
			mode = (size_r > size_ext_limit) ? addr_max : addr_ext;
		else
			mode = (size_r > size_min_limit) ? addr_max : addr_min;
	end

	// -----------------------------------------------------------
	// host handshake and port arbitration
	// -----------------------------------------------------------
	// host pointer is the one the host side moves
	logic [15:0] host_ptr;
	logic at_halt, host_want, req_r;
	assign host_ptr = dir_in ? rd_ptr_r : wr_ptr_r;
	assign at_halt = (host_ptr == halt_ptr_r);
	// sticky done bit does not gate requests, so a new halt pointer resumes them
	assign host_want = tc_r[tc_host_run_bit] && !at_halt;
	assign done_set = tc_r[tc_host_run_bit] && at_halt;

	// maximum mode spends the strobe's cycle on the high byte, then accesses
	logic dev_d_r, dev_pend, high_phase;
	always_ff @(posedge clk)
		dev_d_r <= wipe ? 1'b0 : dev_s;

	// device always wins; ack is a level, so a blocked host access is only delayed
	assign dev_go = ((mode == addr_max) ? dev_d_r : dev_s) && !wipe;
	assign dev_pend = dev_go || ((mode == addr_max) && dev_s);
	assign host_go = ack_s && req_r && !dev_pend && !wipe;

	always_ff @(posedge clk)
	begin
		if (wipe)
			req_r <= 1'b0;
		else if (host_go)
			req_r <= 1'b0;
		else if (host_want && !ack_s && !done_set)
			req_r <= 1'b1;
	end

	// maximum mode: every cycle without an access shows the high byte
	assign high_phase = (mode == addr_max) && !dev_go && !host_go;

	// -----------------------------------------------------------
	// buffer access and pins
	// -----------------------------------------------------------
	logic win_rd, win_wr, host_port_wr, dev_buf_wr, host_buf_wr;
	// one memory select per read, however long the strobe stands
	assign win_rd = cs_s && rd_s && !rd_d_r && hit(reg_addr_r, buffer_window_port);
	assign win_wr = store_ev && hit(reg_addr_r, buffer_window_port);
	assign host_port_wr = store_ev && (hit(reg_addr_r, host_bus_low_port)
		|| hit(reg_addr_r, host_bus_high_port));
	assign dev_buf_wr = dev_go && dir_in;
	assign host_buf_wr = host_go && !dir_in;
	logic [15:0] cur_addr;
	assign cur_addr = (dev_pend ? dir_in : !dir_in) ? wr_ptr_r : rd_ptr_r;

	logic [7:0] al;
	logic a8, a9, a12, a13;
	logic [1:0] a10_11;
	bsm_addr_mux mux_i (
		.mode(mode),
		.high_phase(high_phase),
		.host_access(host_go || req_r),
		.device_access(dev_pend),
		.addr(cur_addr),
		.addr_low(al),
		.pin_a8(a8),
		.pin_a9(a9),
		.pin_a10_11(a10_11),
		.pin_a12(a12),
		.pin_a13(a13)
	);

	logic arb_phase;
	bsm_arbiter arb_i (
		.clk(clk),
		.rst(wipe),
		.arb_enable(hic_r[hic_arb_bit]),
		.busy_sense(busy_s),
		.pick_sense(pick_s),
		.arb_phase(arb_phase)
	);

	// all outputs registered
	always_ff @(posedge clk)
	begin
		if (wipe)
		begin
			buf_addr_low <= 8'h00;
			host_latch_strobe <= 1'b0;
			device_latch_strobe <= 1'b0;
			buf_addr_mid <= 2'b00;
			host_latch_output_en <= 1'b1;
			device_latch_output_en <= 1'b1;
			memory_select <= 1'b0;
			buffer_store_en <= 1'b0;
			data_hold_strobe <= 1'b0;
			host_req <= 1'b0;
		end
		else
		begin
			buf_addr_low <= al;
			host_latch_strobe <= a8;
			device_latch_strobe <= a9;
			buf_addr_mid <= a10_11;
			host_latch_output_en <= a12;
			device_latch_output_en <= a13;
			memory_select <= dev_go || host_go || win_rd || win_wr;
			buffer_store_en <= dev_buf_wr || host_buf_wr || win_wr;
			data_hold_strobe <= host_port_wr;
			host_req <= req_r;
		end
	end

	// bus pins follow control bits or transfer logic
	always_ff @(posedge clk)
	begin
		if (wipe)
		begin
			busy_drive_out <= 1'b0;
			target_pick_out <= 1'b0;
			slave_role_out <= 1'b0;
			master_role_out <= 1'b0;
			bus_input_enable <= 1'b0;
			bus_output_enable <= 1'b0;
		end
		else
		begin
			busy_drive_out <= hic_r[hic_busy_bit] || arb_phase;
			target_pick_out <= hic_r[hic_pick_bit];
			slave_role_out <= hic_r[hic_slave_bit];
			master_role_out <= hic_r[hic_master_bit];
			bus_input_enable <= hic_r[hic_in_en_bit]
				|| (tc_r[tc_host_run_bit] && !dir_in);
			bus_output_enable <= hic_r[hic_out_en_bit]
				|| (tc_r[tc_host_run_bit] && dir_in);
		end
	end

	// -----------------------------------------------------------
	// read back
	// -----------------------------------------------------------
	// reading while chip select and read strobe stand drives the bus
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mux_bus_out <= 8'h00;
			mux_bus_oe_n <= 1'b1;
		end
		else
		begin
			mux_bus_oe_n <= !(cs_s && rd_s);
			unique case (reg_addr_r)
				host_interface_control: mux_bus_out <= hic_r;
				transfer_control: mux_bus_out <= tc_r;
				buffer_size: mux_bus_out <= size_r;
				address_mode_control: mux_bus_out <= amc_r;
				reset_control: mux_bus_out <= {7'h00, rst_flag_r};
				read_pointer_low: mux_bus_out <= rd_ptr_r[7:0];
				read_pointer_high: mux_bus_out <= rd_ptr_r[15:8];
				write_pointer_low: mux_bus_out <= wr_ptr_r[7:0];
				write_pointer_high: mux_bus_out <= wr_ptr_r[15:8];
				halt_pointer_low: mux_bus_out <= halt_ptr_r[7:0];
				halt_pointer_high: mux_bus_out <= halt_ptr_r[15:8];
				default: mux_bus_out <= 8'h00;
			endcase
		end
	end
endmodule

/* tb/bsm_asserts.sv */
// --------
// checks at the pins
// --------
module bsm_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// inputs seen
	input wire logic chip_select,
	input wire logic read_strobe,
	input wire logic device_transfer_strobe,
	input wire logic host_ack,
	// outputs seen
	input wire logic mux_bus_oe_n,
	input wire logic host_latch_output_en,
	input wire logic device_latch_output_en,
	input wire logic memory_select,
	input wire logic buffer_store_en,
	input wire logic busy_drive_out,
	input wire logic data_hold_strobe,
	input wire logic host_req
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);
	// reset must idle outputs even while held
	reset_idle_a:
		assert property (disable iff (1'b0) rst |=> !host_req && !busy_drive_out
			&& host_latch_output_en && device_latch_output_en && mux_bus_oe_n)
		else $error("outputs not idle after reset");
	read_drive_a:
		assert property ($fell(mux_bus_oe_n) |-> $past(chip_select) && $past(read_strobe))
		else $error("bus driven without read");
	dev_xfer_a:
		assert property ($rose(device_transfer_strobe) |-> ##[1:4] memory_select)
		else $error("device strobe without buffer access");
	store_sel_a:
		assert property (buffer_store_en |-> memory_select)
		else $error("store enable without memory select");
	hold_pulse_a:
		assert property (data_hold_strobe |=> !data_hold_strobe)
		else $error("data hold strobe too long");
	ack_done_a:
		assert property (host_req && host_ack |-> ##[1:12] !host_req)
		else $error("request not dropped after ack");
	req_fall_a:
		assert property ($fell(host_req) |-> $past(host_ack))
		else $error("request dropped without ack");
	req_alt_a:
		assert property ($rose(host_req) |-> !host_ack && !$past(host_ack))
		else $error("request raised while ack high");
	// main scenarios reached
	cover property (host_req && host_ack);
	cover property (buffer_store_en);
	cover property ($fell(mux_bus_oe_n));
endmodule

bind buffer_storage_manager_io bsm_asserts bsm_asserts_inst (.clk, .rst, .chip_select,
	.read_strobe, .device_transfer_strobe, .host_ack, .mux_bus_oe_n, .host_latch_output_en,
	.device_latch_output_en, .memory_select, .buffer_store_en, .busy_drive_out,
	.data_hold_strobe, .host_req);

/* tb/host_port_model.sv */
// --------
// host end of the handshake
// --------
module host_port_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// handshake
	input wire logic host_req,
	input wire logic slow,
	output logic host_ack,
	output int ack_count
);
	timeunit 1ns;
	timeprecision 1ps;
	// ack held until request drops, since a short ack may be lost
	initial
	begin
		host_ack = 1'b0;
		ack_count = 0;
		forever
		begin
			@(posedge clk);
			if (host_req === 1'b1 && rst === 1'b0)
			begin
				repeat (slow ? 6 : 1) @(posedge clk);
				host_ack <= 1'b1;
				ack_count <= ack_count + 1;
				for (int i = 0; i < 100 && host_req !== 1'b0; i++)
					@(posedge clk);
				host_ack <= 1'b0;
			end
		end
	end
endmodule

/* tb/buffer_storage_manager_io_tb.sv */
module buffer_storage_manager_io_tb;
	import bsm_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// --------
	// signals
	// --------
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic reset_pin_n = 1'b0;
	logic chip_select = 1'b0;
	logic addr_latch_en = 1'b0;
	logic read_strobe = 1'b0;
	logic store_strobe = 1'b0;
	logic [7:0] mux_bus_in = 8'h00;
	logic device_transfer_strobe = 1'b0;
	logic pick_sense_in = 1'b0;
	logic busy_sense_in = 1'b0;
	logic slow = 1'b0;
	logic [7:0] mux_bus_out, buf_addr_low, r;
	logic [1:0] buf_addr_mid;
	logic mux_bus_oe_n, host_latch_strobe, device_latch_strobe, host_latch_output_en;
	logic device_latch_output_en, memory_select, buffer_store_en, busy_drive_out;
	logic target_pick_out, slave_role_out, master_role_out, bus_input_enable;
	logic bus_output_enable, data_hold_strobe, host_ack, host_req;
	logic [15:0] mc = 16'h0000, sc = 16'h0000, hc = 16'h0000, lc = 16'h0000, d, e, p;
	int ack_count, fail_count = 0, check_count = 0;
	buffer_storage_manager_io buffer_storage_manager_io_inst (.clk, .rst, .reset_pin_n,
		.chip_select, .addr_latch_en, .read_strobe, .store_strobe, .mux_bus_in,
		.mux_bus_out, .mux_bus_oe_n, .device_transfer_strobe, .buf_addr_low,
		.host_latch_strobe, .device_latch_strobe, .buf_addr_mid, .host_latch_output_en,
		.device_latch_output_en, .memory_select, .buffer_store_en, .busy_sense_in,
		.pick_sense_in, .busy_drive_out, .target_pick_out, .slave_role_out,
		.master_role_out, .bus_input_enable, .bus_output_enable, .data_hold_strobe,
		.host_ack, .host_req);
	host_port_model host_port_model_inst (.clk, .rst, .host_req, .slow, .host_ack,
		.ack_count);
	always #10 clk = ~clk;
	// pulse counters, so short strobes are never missed
	always @(posedge clk)
	begin
		if (memory_select === 1'b1)
			mc <= mc + 16'h0001;
		if (buffer_store_en === 1'b1)
			sc <= sc + 16'h0001;
		if (data_hold_strobe === 1'b1)
			hc <= hc + 16'h0001;
		if (device_latch_strobe === 1'b1)
			lc <= lc + 16'h0001;
	end
	// --------
	// bus cycles and compare
	// --------
	task check_val(input string n, input logic [15:0] x, input logic [15:0] g);
		check_count++;
		if (g !== x)
		begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", n, x, g);
		end
	endtask
	task cycles(input int n);
		repeat (n) @(negedge clk);
	endtask
	// inputs are synchronised, so address and store strobes are held four cycles, read strobe five
	task bus_addr(input logic [7:0] a);
		mux_bus_in = a;
		addr_latch_en = 1'b1;
		cycles(4);
		addr_latch_en = 1'b0;
		cycles(4);
	endtask
	task bus_write(input logic [7:0] a, input logic [7:0] v);
		bus_addr(a);
		mux_bus_in = v;
		chip_select = 1'b1;
		store_strobe = 1'b1;
		cycles(4);
		store_strobe = 1'b0;
		chip_select = 1'b0;
		cycles(4);
	endtask
	task read_check(input string n, input logic [7:0] a, input logic [7:0] x);
		bus_addr(a);
		chip_select = 1'b1;
		read_strobe = 1'b1;
		cycles(5);
		r = mux_bus_out;
		check_val("bus drive", 1'h0, mux_bus_oe_n);
		read_strobe = 1'b0;
		chip_select = 1'b0;
		cycles(4);
		check_val(n, x, r);
	endtask
	task set_rp(input logic [15:0] v);
		bus_write(read_pointer_low, v[7:0]);
		bus_write(read_pointer_high, v[15:8]);
	endtask
	// pins caught in the cycle memory select is seen
	task dev_xfer;
		p = 16'hffff;
		device_transfer_strobe = 1'b1;
		cycles(1);
		device_transfer_strobe = 1'b0;
		for (int i = 0; i < 6 && p === 16'hffff; i++)
		begin
			if (memory_select === 1'b1)
				p = {buf_addr_low, host_latch_strobe, device_latch_strobe, buf_addr_mid,
					host_latch_output_en, device_latch_output_en, buffer_store_en, 1'b0};
			else
				@(negedge clk);
		end
		if (p === 16'hffff)
		begin
			fail_count++;
			$display("unexpected buffer access: expected %h seen %h", 1'h1, memory_select);
			stop_test();
		end
		cycles(4);
	endtask
	task wait_acks(input int n);
		for (int i = 0; i < 600 && ack_count < n; i++)
			@(negedge clk);
		if (ack_count < n)
		begin
			fail_count++;
			$display("unexpected acks: expected %0d seen %0d", n, ack_count);
			stop_test();
		end
	endtask
	// --------
	// scenarios
	// --------
	task test_reset;
		check_val("req", 1'h0, host_req);
		check_val("latch en", 2'h3, {host_latch_output_en, device_latch_output_en});
		read_check("reset control", reset_control, 8'h01);
		$display("reset test done");
	endtask
	task test_hic;
		bus_write(host_interface_control, 8'hde);
		check_val("hic pins", 16'h003f, {busy_drive_out, target_pick_out, bus_output_enable,
			bus_input_enable, slave_role_out, master_role_out});
		read_check("hic", host_interface_control, 8'hde);
		busy_sense_in = 1'b1;
		bus_write(host_interface_control, 8'h20);
		cycles(12);
		check_val("busy wait", 1'h0, busy_drive_out);
		busy_sense_in = 1'b0;
		cycles(12);
		check_val("arb busy", 1'h1, busy_drive_out);
		pick_sense_in = 1'b1;
		cycles(6);
		check_val("pick restart", 1'h0, busy_drive_out);
		pick_sense_in = 1'b0;
		bus_write(host_interface_control, 8'h00);
		$display("control test done");
	endtask
	task test_ports;
		d = hc;
		bus_write(host_bus_low_port, 8'h5a);
		check_val("hold low", d + 16'h0001, hc);
		bus_write(host_bus_high_port, 8'ha5);
		check_val("hold high", d + 16'h0002, hc);
		read_check("unmapped", 8'h60, 8'h00);
		d = mc;
		e = sc;
		read_check("window", buffer_window_port, 8'h00);
		check_val("win rd sel", d + 16'h0001, mc);
		check_val("win rd store", e, sc);
		bus_write(buffer_window_port, 8'h3c);
		check_val("win wr sel", d + 16'h0002, mc);
		check_val("win wr store", e + 16'h0001, sc);
		$display("port test done");
	endtask
	task test_modes;
		bus_write(transfer_control, 8'h00);
		bus_write(buffer_size, 8'h03);
		set_rp(16'h0255);
		dev_xfer();
		check_val("min pins", 16'h554c, p & 16'hffcf);
		bus_write(address_mode_control, 8'h01);
		bus_write(buffer_size, 8'h3f);
		set_rp(16'h2a55);
		dev_xfer();
		check_val("ext pins", 16'h5564, p);
		bus_write(address_mode_control, 8'h00);
		set_rp(16'h0255);
		d = lc;
		dev_xfer();
		check_val("max pins", 16'h0008, p & 16'h000e);
		check_val("dev latch", 1'h1, lc != d);
		bus_write(buffer_size, 8'h03);
		bus_write(transfer_control, 8'h10);
		dev_xfer();
		check_val("dev store", 16'h0002, p & 16'h0002);
		bus_write(transfer_control, 8'h00);
		$display("mode test done");
	endtask
	task test_host;
		bus_write(reset_control, 8'h00);
		read_check("ptr clear", write_pointer_low, 8'h00);
		bus_write(transfer_control, 8'h01);
		e = sc;
		bus_write(halt_pointer_low, 8'h03);
		wait_acks(3);
		cycles(20);
		check_val("acks", 16'h0003, 16'(ack_count));
		check_val("req halted", 1'h0, host_req);
		check_val("host stores", e + 16'h0003, sc);
		read_check("done", transfer_control, 8'h21);
		slow = 1'b1;
		bus_write(halt_pointer_low, 8'h05);
		wait_acks(5);
		cycles(20);
		check_val("resumed", 16'h0005, 16'(ack_count));
		read_check("wr ptr", write_pointer_low, 8'h05);
		slow = 1'b0;
		$display("host test done");
	endtask
	task test_soft;
		bus_write(host_interface_control, 8'h80);
		check_val("busy", 1'h1, busy_drive_out);
		bus_write(reset_control, 8'h01);
		check_val("busy off", 1'h0, busy_drive_out);
		read_check("hic off", host_interface_control, 8'h00);
		bus_write(reset_control, 8'h00);
		bus_write(host_interface_control, 8'h80);
		reset_pin_n = 1'b0;
		cycles(4);
		reset_pin_n = 1'b1;
		cycles(4);
		check_val("pin reset", 1'h0, busy_drive_out);
		read_check("pin flag", reset_control, 8'h01);
		$display("soft reset test done");
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// main sequence
	initial
	begin
		cycles(4);
		rst = 1'b0;
		reset_pin_n = 1'b1;
		cycles(4);
		test_reset();
		test_hic();
		test_ports();
		test_modes();
		test_host();
		test_soft();
		stop_test();
	end
endmodule
